/* rtl/pldsl_driver.sv */
// Functional notes
// R1 - controller splits each line into two streams
// R2 - falling shift clock advances both chains together
// R3 - even chain takes second input, shifts upward
// R4 - odd chain takes first input, shifts upward
// R5 - latch load high makes latches follow stages
// R6 - latch load falling captures, low holds
// R7 - force-on with output-hold drives all lines on
// R8 - force-on low, hold high shows latches
// R9 - output-hold low forces every line off
// R10 - cascade outputs show stages 31 and 32
// R11 - cascade outputs ignore all three controls; here latch load high stalls the chains and freezes them
// R12 - two 16-stage chains, 32 latches, 32 lines
// R13 - controller gives 16 edges then latch pulse
// R14 - no reset; contents meaningless until loaded; here sys_rst_i clears stages, latches and lines to zeros
`default_nettype none
module pldsl_driver
  import pldsl_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               shift_clk_i,
  input  wire logic               odd_serial_input_i,
  input  wire logic               even_serial_input_i,
  input  wire pldsl_ctrl_t        ctrl_i,
  output logic                    in_ready_o,
  output logic [LINE_COUNT-1:0]   line_outputs_o,
  output logic                    odd_cascade_output_o,
  output logic                    even_cascade_output_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic                  shclk_prev_r, shclk_prev_nxt;
  logic [LINE_COUNT-1:0] shift_stages_r, shift_stages_nxt;
  logic [LINE_COUNT-1:0] held_line_bits_r, held_line_bits_nxt;
  logic [LINE_COUNT-1:0] lines_r, lines_nxt;
  logic                  shclk_fall;
  logic                  pair_valid;
  logic                  pair_take;
  pldsl_pair_t           pair_in;
  pldsl_pair_t           pair_out;

  // one step of both chains: stage n takes stage n-2, inputs enter at 1 and 2
  function automatic logic [LINE_COUNT-1:0] shift_pair(
    input logic [LINE_COUNT-1:0] s,
    input pldsl_pair_t           p
  );
    return {s[LINE_COUNT-3:0], p.even, p.odd};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // shift clock edge detect and entry buffer

  // falling edge of the sampled shift clock
  always_comb begin
    shclk_prev_nxt = shift_clk_i;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      shclk_prev_r <= SHCLK_RST;
    end else begin
      shclk_prev_r <= shclk_prev_nxt;
    end
  end

  assign shclk_fall   = shclk_prev_r & ~shift_clk_i; // see R2
  assign pair_in.odd  = odd_serial_input_i;
  assign pair_in.even = even_serial_input_i;

  // chains stall while the latch is open, so a load never tears mid-shift;
  // the buffer absorbs edges meanwhile and in_ready_o warns the source
  assign pair_take = pair_valid & ~ctrl_i.latch_load;

  pldsl_fifo #(
    .WIDTH ($bits(pldsl_pair_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_entry_fifo (
    .mclk_i      (mclk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (shclk_fall),
    .in_ready_o  (in_ready_o),
    .in_data_i   (pair_in),
    .out_valid_o (pair_valid),
    .out_ready_i (pair_take),
    .out_data_o  (pair_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shift chains, latches, line gating

  always_comb begin
    shift_stages_nxt = shift_stages_r;
    if (pair_take) begin
      shift_stages_nxt = shift_pair(shift_stages_r, pair_out); // see R3 R4
    end
    // transparent while high, keeps last value while low
    held_line_bits_nxt = ctrl_i.latch_load ? shift_stages_r
                                           : held_line_bits_r; // see R5 R6
    // hold low wins over force-on
    if (!ctrl_i.output_hold) begin
      lines_nxt = LINES_OFF; // see R9
    end else if (ctrl_i.force_on) begin
      lines_nxt = LINES_ON; // see R7
    end else begin
      lines_nxt = held_line_bits_r; // see R8
    end
  end

  // reset gives known zeros; software must still load before use
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      shift_stages_r   <= STAGES_RST; // see R14
      held_line_bits_r <= HELD_RST;
      lines_r          <= LINES_OFF;
    end else begin
      shift_stages_r   <= shift_stages_nxt; // see R2 R12
      held_line_bits_r <= held_line_bits_nxt;
      lines_r          <= lines_nxt;
    end
  end

  // cascade taps come straight from chain flops, no control in the path
  assign odd_cascade_output_o  = shift_stages_r[ODD_TAIL_POS]; // see R10 R11
  assign even_cascade_output_o = shift_stages_r[EVEN_TAIL_POS]; // see R10
  assign line_outputs_o        = lines_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_load_open;
    ctrl_i.latch_load;
  endsequence

  sequence s_load_drop;
    s_load_open ##1 !ctrl_i.latch_load;
  endsequence

  a_chain_hold: assert property ( // see R2
    !pair_take |=> $stable(shift_stages_r))
    else $error("chains moved without a shift");

  a_even_entry: assert property ( // see R3
    pair_take |=> shift_stages_r[1] == $past(pair_out.even))
    else $error("even chain entry wrong");

  a_odd_entry: assert property ( // see R4
    pair_take |=> shift_stages_r[0] == $past(pair_out.odd))
    else $error("odd chain entry wrong");

  a_upper_shift: assert property ( // see R3 R4
    pair_take |=> shift_stages_r[31:2] == $past(shift_stages_r[29:0]))
    else $error("chain stages did not move up by two");

  a_latch_follow: assert property ( // see R5
    s_load_open |=> held_line_bits_r == $past(shift_stages_r))
    else $error("open latch did not follow stages");

  // closed latch keeps its word for every cycle that the load stays low
  a_latch_keep: assert property ( // see R6
    !ctrl_i.latch_load |=> $stable(held_line_bits_r))
    else $error("closed latch changed");

  a_latch_capture: assert property ( // see R6
    s_load_drop |-> held_line_bits_r == $past(shift_stages_r))
    else $error("falling load did not capture stages");

  a_force_on: assert property ( // see R7
    ctrl_i.output_hold && ctrl_i.force_on |=> line_outputs_o == LINES_ON)
    else $error("lines not all on");

  a_pass_latch: assert property ( // see R8
    ctrl_i.output_hold && !ctrl_i.force_on
      |=> line_outputs_o == $past(held_line_bits_r))
    else $error("lines do not show latches");

  a_all_off: assert property ( // see R9
    !ctrl_i.output_hold |=> line_outputs_o == LINES_OFF)
    else $error("lines not off");

  a_cascade_tap: assert property ( // see R10
    pair_take |=> odd_cascade_output_o == $past(shift_stages_r[28])
      && even_cascade_output_o == $past(shift_stages_r[29]))
    else $error("cascade taps wrong");

  a_cascade_free: assert property ( // see R11
    !pair_take |=> $stable(odd_cascade_output_o)
      && $stable(even_cascade_output_o))
    else $error("cascade moved with controls");

endmodule // pldsl_driver
`default_nettype wire

/* rtl/pldsl_fifo.sv */
`default_nettype none
module pldsl_fifo
  import pldsl_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             mclk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r   [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt;
  logic [AW-1:0]    rd_ptr_r, rd_ptr_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  // wrap by compare so depths that are not powers of two also work
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  // honest flags straight from the occupancy count
  assign in_ready_o  = (cnt_r != FULL_CNT);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // pointer and storage update
  always_comb begin
    mem_nxt    = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    cnt_nxt    = cnt_r;
    if (push) begin
      mem_nxt[wr_ptr_r] = in_data_i;
      wr_ptr_nxt        = bump(wr_ptr_r);
    end
    if (pop) begin
      rd_ptr_nxt = bump(rd_ptr_r);
    end
    case ({push, pop})
      2'b10:   cnt_nxt = cnt_r + 1'b1;
      2'b01:   cnt_nxt = cnt_r - 1'b1;
      default: cnt_nxt = cnt_r;
    endcase
  end

  // control registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

  // storage needs no reset, nothing reads an empty slot
  always_ff @(posedge mclk_i) begin
    mem_r <= mem_nxt;
  end

endmodule // pldsl_fifo
`default_nettype wire

/* rtl/pldsl_pkg.sv */
`default_nettype none
package pldsl_pkg;

  // geometry of the driver
  localparam int LINE_COUNT = 32;
  localparam int CHAIN_LEN  = 16;
  localparam int FIFO_DEPTH = 16;

  // positions of the cascade taps inside the stage vector (stage n at n-1)
  localparam int ODD_TAIL_POS  = 30;
  localparam int EVEN_TAIL_POS = 31;

  // reset values and the force-on line pattern
  localparam logic [31:0] STAGES_RST = 32'h0000_0000;
  localparam logic [31:0] HELD_RST   = 32'h0000_0000;
  localparam logic [31:0] LINES_OFF  = 32'h0000_0000;
  localparam logic [31:0] LINES_ON   = 32'hFFFF_FFFF;
  localparam logic        SHCLK_RST  = 1'b0;

  // one bit for each chain, taken on the same shift clock edge
  typedef struct packed {
    logic even;
    logic odd;
  } pldsl_pair_t;

  // the three level controls from the panel controller
  typedef struct packed {
    logic latch_load;
    logic force_on;
    logic output_hold;
  } pldsl_ctrl_t;

endpackage
`default_nettype wire

/* tb/pldsl_ctl_model.sv */
`default_nettype none
module pldsl_ctl_model
  import pldsl_pkg::*;
(
  input  wire logic  mclk_i,
  output logic       shift_clk_o,
  output logic       odd_o,
  output logic       even_o,
  output pldsl_ctrl_t ctrl_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle levels at time zero: clock parked high, outputs off
  initial begin
    shift_clk_o = 1'b1;
    odd_o       = 1'b0;
    even_o      = 1'b0;
    ctrl_o      = 3'b000;
  end

  // one line split into two streams, first pair lands in stages 31/32
  // gap adds idle cycles per edge to play a slow controller
  task automatic send_line(input logic [31:0] line, input int gap = 0);
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk_i);
      shift_clk_o <= 1'b1;
      odd_o       <= ~odd_o; // released data no longer shows old bit
      even_o      <= ~even_o;
      repeat (gap) @(posedge mclk_i);
      @(posedge mclk_i);
      shift_clk_o <= 1'b0;
      odd_o       <= line[30-2*i];
      even_o      <= line[31-2*i];
    end
    @(posedge mclk_i);
    shift_clk_o <= 1'b1;
    odd_o       <= ~odd_o;
    even_o      <= ~even_o;
  endtask

  // control levels change only just after a rising edge
  task automatic set_ctrl(input pldsl_ctrl_t c);
    @(posedge mclk_i);
    ctrl_o <= c;
  endtask

  // latch-load moved alone, the gating levels keep what they had
  task automatic open_load();
    @(posedge mclk_i);
    ctrl_o.latch_load <= 1'b1;
  endtask

  task automatic close_load();
    @(posedge mclk_i);
    ctrl_o.latch_load <= 1'b0;
  endtask

  // one cycle of load, the shortest pulse the latch must honour
  task automatic pulse_load();
    open_load();
    close_load();
  endtask
endmodule // pldsl_ctl_model
`default_nettype wire

/* tb/testbench.sv */
`default_nettype none
module testbench
  import pldsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk_i    = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        shift_clk, odd_in, even_in, in_ready;
  logic        odd_casc, even_casc;
  logic [31:0] lines;
  pldsl_ctrl_t ctrl;
  int          n_errors = 0;
  int          checks   = 0;
  int          cycles   = 0;

  localparam logic [31:0] LA = 32'hA5C3_1E07;
  localparam logic [31:0] LB = 32'h5A3C_E1F8;
  localparam logic [31:0] LC = 32'h8001_7FFE;

  always #2.5 mclk_i = ~mclk_i;

  pldsl_ctl_model ctl (
    .mclk_i      (mclk_i),
    .shift_clk_o (shift_clk),
    .odd_o       (odd_in),
    .even_o      (even_in),
    .ctrl_o      (ctrl)
  );

  pldsl_driver uut (
    .mclk_i                (mclk_i),
    .sys_rst_i             (sys_rst_i),
    .shift_clk_i           (shift_clk),
    .odd_serial_input_i    (odd_in),
    .even_serial_input_i   (even_in),
    .ctrl_i                (ctrl),
    .in_ready_o            (in_ready),
    .line_outputs_o        (lines),
    .odd_cascade_output_o  (odd_casc),
    .even_cascade_output_o (even_casc)
  );

  task automatic finish_test();
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // settle past the edge before sampling
  task automatic idle(int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic check_casc(logic [31:0] l);
    check("odd_cascade", 32'(odd_casc), 32'(l[30]));
    check("even_cascade", 32'(even_casc), 32'(l[31]));
  endtask

  // full load, latch pulse, lines show the latches
  task automatic test_load();
    ctl.send_line(LA);
    idle(4);
    check_casc(LA);
    ctl.pulse_load();
    ctl.set_ctrl(3'b001);
    idle(4);
    check("lines", lines, LA);
  endtask

  // slow shifting while latches hold, then the gating controls
  task automatic test_hold_gate();
    ctl.send_line(LB, 2);
    idle(4);
    check("lines", lines, LA);
    check_casc(LB);
    ctl.set_ctrl(3'b011);
    idle(3);
    check("lines", lines, LINES_ON);
    check_casc(LB);
    ctl.set_ctrl(3'b010);
    idle(3);
    check("lines", lines, LINES_OFF);
    ctl.pulse_load();
    idle(4);
    check("lines", lines, LINES_OFF);
    check_casc(LB);
    ctl.set_ctrl(3'b001);
    idle(3);
    check("lines", lines, LB);
  endtask

  // latch held open stalls shifting: buffer fills, then drains
  task automatic test_fifo();
    ctl.open_load();
    ctl.send_line(LC);
    idle(2);
    check("in_ready", 32'(in_ready), 32'h0000_0000);
    check_casc(LB);
    ctl.close_load();
    idle(24);
    check("in_ready", 32'(in_ready), 32'h0000_0001);
    check_casc(LC);
    check("lines", lines, LB);
    ctl.pulse_load();
    idle(4);
    check("lines", lines, LC);
  endtask

  // cut a hang short
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (16) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    idle(2);
    test_load();
    test_hold_gate();
    test_fifo();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
